// ===== bench/ascm_mem_model.sv
/*
  Coherent memory side: keeps the last stored word, issues other agents'
  stores and cache operations as snoops. Assumes one-cycle requests.
*/
`timescale 1ns/10ps
`default_nettype none

module ascm_mem_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Store from the monitor
  input wire logic mem_wr,
  input wire ascm_pkg::ascm_word_t mem_data,
  // Other agent request, bit 0 store, bit 1 cache op
  input wire logic [1:0] agent_req,
  input wire ascm_pkg::ascm_word_t agent_addr,
  // Snoops
  output logic snoop_store,
  output logic snoop_cacheop,
  output ascm_pkg::ascm_word_t snoop_addr,
  // Memory view
  output ascm_pkg::ascm_word_t last_data
);
  import ascm_pkg::*;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      snoop_store <= 1'b0;
      snoop_cacheop <= 1'b0;
      snoop_addr <= '0;
    end else begin
      snoop_store <= agent_req[0];
      snoop_cacheop <= agent_req[1];
      // Idle address flips so no stale match
      snoop_addr <= (|agent_req) ? agent_addr : ~snoop_addr;
    end
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      last_data <= '0;
    end else if (mem_wr) begin
      last_data <= mem_data;
    end
  end
endmodule // ascm_mem_model

`default_nettype wire

// ===== bench/ascm_monitor_assertions.sv
/*
  Port checker for the reservation monitor.
  Assumes one clock domain; bound to the monitor by the statement below.
*/
`timescale 1ns/10ps
`default_nettype none

module ascm_monitor_assertions #(
  parameter int BLOCK_LOG2 = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Watched inputs
  input wire logic [31:0] instr,
  input wire ascm_pkg::ascm_word_t dsr_value,
  input wire logic load_linked_word,
  input wire ascm_pkg::ascm_word_t ll_addr,
  input wire logic exception_return,
  input wire logic exception_return_keep_link,
  input wire logic snoop_store,
  input wire ascm_pkg::ascm_word_t snoop_addr,
  // Watched outputs
  input wire logic mem_wr,
  input wire ascm_pkg::ascm_word_t mem_addr,
  input wire ascm_pkg::ascm_word_t mem_data,
  input wire logic rf_wr,
  input wire ascm_pkg::ascm_reg_t rf_index,
  input wire ascm_pkg::ascm_word_t rf_data,
  input wire logic exc_valid,
  input wire logic reservation_valid
);
  import ascm_pkg::*;
  ascm_word_t held;
  ascm_reg_t dst_field;
  assign dst_field = instr[25:21];
  // Shadow of the linked address for block and word compares
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      held <= '0;
    end else if (load_linked_word) begin
      held <= ll_addr;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence s_quiet;
    !mem_wr ##1 (!mem_wr && !rf_wr);
  endsequence
  sequence s_ok_back;
    ##1 (rf_wr && rf_data == 32'h00000001);
  endsequence
  wr_whole_a: assert property (
    mem_wr |-> mem_data == $past(dsr_value, 2))
    else $error("store data differs from source word");
  ok_flag_a: assert property (mem_wr |-> s_ok_back)
    else $error("no success code after store");
  fail_zero_a: assert property (
    rf_wr && !$past(mem_wr) |-> rf_data == 32'h00000000)
    else $error("failed store did not return zero");
  dst_index_a: assert property (
    rf_wr |-> rf_index == $past(dst_field, 3))
    else $error("result went to wrong register");
  same_addr_a: assert property (
    mem_wr |-> mem_addr[31:2] == $past(held[31:2], 2))
    else $error("store written to unlinked address");
  flag_gate_a: assert property (
    mem_wr |-> $past(reservation_valid, 2))
    else $error("store written without reservation");
  snoop_kill_a: assert property (
    snoop_store && !load_linked_word &&
    (snoop_addr >> BLOCK_LOG2) == (held >> BLOCK_LOG2)
    |-> ##[1:2] !reservation_valid)
    else $error("foreign store kept reservation");
  exception_return_kill_a: assert property (
    exception_return && !exception_return_keep_link && !load_linked_word
    |-> ##[1:2] !reservation_valid)
    else $error("exception return kept reservation");
  link_set_a: assert property (
    load_linked_word && !exception_return && !snoop_store
    |-> ##[1:2] reservation_valid)
    else $error("linked load did not reserve");
  exc_quiet_a: assert property (exc_valid |-> s_quiet)
    else $error("store went on after exception");
  clear_after_a: assert property (
    rf_wr && !load_linked_word && !$past(load_linked_word) &&
    !$past(load_linked_word, 2) && !$past(load_linked_word, 3)
    |-> !reservation_valid)
    else $error("reservation left set after store");
endmodule // ascm_monitor_assertions

bind ascm_monitor ascm_monitor_assertions #(.BLOCK_LOG2(BLOCK_LOG2))
  ascm_monitor_assertions_i (
    .mclk(mclk), .rstn(rstn), .instr(instr), .dsr_value(dsr_value),
    .load_linked_word(load_linked_word), .ll_addr(ll_addr),
    .exception_return(exception_return),
    .exception_return_keep_link(exception_return_keep_link),
    .snoop_store(snoop_store), .snoop_addr(snoop_addr),
    .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_data(mem_data),
    .rf_wr(rf_wr), .rf_index(rf_index), .rf_data(rf_data),
    .exc_valid(exc_valid), .reservation_valid(reservation_valid)
  );

`default_nettype wire

// ===== bench/ascm_monitor_bench.sv
/*
  Self-checking bench for the reservation monitor.
  Assumes the checker is bound from its own file.
*/
`timescale 1ns/10ps
`default_nettype none

module ascm_monitor_bench;
  import ascm_pkg::*;
  logic mclk, rstn, strict_link_config, instr_valid, load_linked_word;
  logic xlat_refill, xlat_invalid, xlat_modified, watch_hit;
  logic exception_return, exception_return_keep_link, local_store;
  logic local_store_coherent, local_load, local_prefetch, local_cacheop;
  logic snoop_store, snoop_cacheop, mem_wr, rf_wr, exc_valid;
  logic reservation_valid;
  logic [31:0] instr;
  logic [4:0] exc_code, exp_code;
  logic [1:0] agent_req;
  ascm_reg_t rf_index;
  ascm_word_t base_value, dsr_value, pc, ll_addr, xlat_paddr, local_addr;
  ascm_word_t snoop_addr, mem_addr, mem_data, rf_data, agent_addr, last_data;
  int errors, cmp_count, cycles;

  ascm_monitor ascm_monitor_i (
    .mclk(mclk), .rstn(rstn), .strict_link_config(strict_link_config),
    .instr_valid(instr_valid), .instr(instr), .base_value(base_value),
    .dsr_value(dsr_value), .pc(pc), .load_linked_word(load_linked_word),
    .ll_addr(ll_addr), .xlat_paddr(xlat_paddr), .xlat_refill(xlat_refill),
    .xlat_invalid(xlat_invalid), .xlat_modified(xlat_modified),
    .watch_hit(watch_hit), .exception_return(exception_return),
    .exception_return_keep_link(exception_return_keep_link),
    .local_store(local_store), .local_store_coherent(local_store_coherent),
    .local_load(local_load), .local_prefetch(local_prefetch),
    .local_cacheop(local_cacheop), .local_addr(local_addr),
    .snoop_store(snoop_store), .snoop_cacheop(snoop_cacheop),
    .snoop_addr(snoop_addr), .mem_wr(mem_wr), .mem_addr(mem_addr),
    .mem_data(mem_data), .rf_wr(rf_wr), .rf_index(rf_index),
    .rf_data(rf_data), .exc_valid(exc_valid), .exc_code(exc_code),
    .reservation_valid(reservation_valid)
  );
  ascm_mem_model ascm_mem_model_i (
    .mclk(mclk), .rstn(rstn), .mem_wr(mem_wr), .mem_data(mem_data),
    .agent_req(agent_req), .agent_addr(agent_addr),
    .snoop_store(snoop_store), .snoop_cacheop(snoop_cacheop),
    .snoop_addr(snoop_addr), .last_data(last_data)
  );

  always #20 mclk = ~mclk;

  task final_report;
    $display("checks %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles needed
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      final_report;
    end
  end

  task automatic chk(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic ll(input ascm_word_t a);
    @(posedge mclk);
    load_linked_word <= 1'b1;
    ll_addr <= a;
    @(posedge mclk);
    load_linked_word <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  task automatic ev(input int k, input ascm_word_t a);
    @(posedge mclk);
    local_addr <= a;
    agent_addr <= a;
    case (k)
      1: agent_req <= 2'h1;
      2: exception_return <= 1'b1;
      3: exception_return_keep_link <= 1'b1;
      4: {local_store, local_store_coherent} <= 2'h3;
      5: local_load <= 1'b1;
      6: local_prefetch <= 1'b1;
      7: local_cacheop <= 1'b1;
      8: agent_req <= 2'h2;
      9: local_store <= 1'b1;
      default: ;
    endcase
    @(posedge mclk);
    {agent_req, exception_return, exception_return_keep_link} <= '0;
    {local_store, local_store_coherent, local_load} <= '0;
    {local_prefetch, local_cacheop} <= '0;
    local_addr <= ~a;
    repeat (3) @(posedge mclk);
  endtask

  task automatic sc(input ascm_word_t b, input logic [8:0] o,
                    input logic [3:0] fn, input logic ok, xe);
    logic w, r, x, rfe;
    w = 1'b0;
    r = 1'b0;
    x = 1'b0;
    rfe = (fn == 4'hB) && !xe;
    @(posedge mclk);
    instr <= {6'h18, 5'h07, 5'h02, fn, 3'h0, o};
    base_value <= b;
    dsr_value <= 32'hA5C30F96;
    xlat_paddr <= b + {{23{o[8]}}, o};
    instr_valid <= 1'b1;
    @(posedge mclk);
    instr_valid <= 1'b0;
    repeat (5) begin
      #1;
      w = w | (mem_wr === 1'b1);
      r = r | (rf_wr === 1'b1);
      x = x | (exc_valid === 1'b1);
      @(posedge mclk);
    end
    chk("exc_valid", 32'(xe), 32'(x));
    if (xe) chk("exc_code", 32'(exp_code), 32'(exc_code));
    chk("mem_wr", 32'(ok), 32'(w));
    if (ok) chk("memory", 32'hA5C30F96, last_data);
    if (ok) chk("mem_addr", 32'h00001000, mem_addr);
    chk("rf_wr", 32'(rfe), 32'(r));
    if (rfe) chk("rf_data", 32'(ok), rf_data);
    if (rfe) chk("rf_index", 32'h7, 32'(rf_index));
  endtask

  // Link, one event, then a store 8 below a base of 0x1008
  task automatic run(input int k, input ascm_word_t a, input logic s, ok);
    strict_link_config <= s;
    ll(32'h00001000);
    ev(k, a);
    sc(32'h00001008, 9'h1F8, 4'hB, ok, 1'b0);
  endtask

  task t_base;
    run(0, 32'h0, 1'b1, 1'b1);
    sc(32'h00001008, 9'h1F8, 4'hB, 1'b0, 1'b0);
    chk("resv", 32'h0, 32'(reservation_valid));
  endtask

  task t_addr;
    ll(32'h00001000);
    sc(32'h00001000, 9'h004, 4'hB, 1'b0, 1'b0);
  endtask

  task t_agent;
    run(1, 32'h00001008, 1'b0, 1'b0);
    run(1, 32'h00001010, 1'b0, 1'b1);
    run(8, 32'h00001004, 1'b1, 1'b0);
  endtask

  task t_exception_return;
    run(2, 32'h0, 1'b0, 1'b0);
    run(3, 32'h0, 1'b0, 1'b1);
  endtask

  task t_local;
    run(4, 32'h0000100C, 1'b1, 1'b0);
    run(5, 32'h0000100C, 1'b1, 1'b1);
    run(6, 32'h00002000, 1'b0, 1'b1);
    run(9, 32'h00001004, 1'b0, 1'b0);
    run(7, 32'h00003000, 1'b1, 1'b0);
  endtask

  // Fault and foreign opcode leave the reservation for a later store
  task t_fault;
    ll(32'h00001000);
    sc(32'h00001000, 9'h002, 4'hB, 1'b0, 1'b1);
    xlat_modified <= 1'b1;
    exp_code = 5'h01;
    sc(32'h00001000, 9'h000, 4'hB, 1'b0, 1'b1);
    xlat_modified <= 1'b0;
    sc(32'h00001000, 9'h000, 4'hA, 1'b0, 1'b0);
    sc(32'h00001000, 9'h000, 4'hB, 1'b1, 1'b0);
  endtask

  // Stray word far above the linked load drops the link
  task t_span;
    ll(32'h00001000);
    pc <= 32'h00001000;
    sc(32'h00001000, 9'h000, 4'hA, 1'b0, 1'b0);
    sc(32'h00001000, 9'h000, 4'hB, 1'b0, 1'b0);
  endtask

  initial begin
    mclk = 1'b0;
    rstn = 1'b0;
    {strict_link_config, instr_valid, load_linked_word} = '0;
    {xlat_refill, xlat_invalid, xlat_modified, watch_hit} = '0;
    {exception_return, exception_return_keep_link, local_store} = '0;
    {local_store_coherent, local_load, local_prefetch, local_cacheop} = '0;
    {instr, base_value, dsr_value, pc, ll_addr} = '0;
    {xlat_paddr, local_addr, agent_addr, agent_req} = '0;
    errors = 0;
    cmp_count = 0;
    cycles = 0;
    exp_code = 5'h05;
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    #1;
    chk("resv", 32'h0, 32'(reservation_valid));
    chk("mem_wr", 32'h0, 32'(mem_wr));
    t_base;
    t_addr;
    t_agent;
    t_exception_return;
    t_local;
    t_fault;
    t_span;
    final_report;
  end
endmodule // ascm_monitor_bench

`default_nettype wire

// ===== logic/ascm_decode.sv
/*
  Instruction decoder and address former for the conditional word store.
  Assumes the instruction word and base register value are stable in the
  cycle they are presented with a valid strobe.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ascm_params.svh"

module ascm_decode (
  // Instruction in
  input wire logic [31:0] instr,
  input wire ascm_pkg::ascm_word_t base_value,
  // Decode out
  output logic is_scw,
  output ascm_pkg::ascm_reg_t dsr_index,
  output ascm_pkg::ascm_word_t eff_addr,
  output logic misaligned
);
  import ascm_pkg::*;

  logic [31:0] ofs_ext;

  assign is_scw = (instr[`ASCM_MAJOR_HI:`ASCM_MAJOR_LO] == `ASCM_MAJOR_OPC)
    && (instr[`ASCM_SUBFN_HI:`ASCM_SUBFN_LO] == `ASCM_SUBFN_SCW)
    && (instr[`ASCM_ZERO_HI:`ASCM_ZERO_LO] == `ASCM_ZERO_FLD); // RL1
  assign dsr_index = instr[`ASCM_DSR_HI:`ASCM_DSR_LO];
  assign ofs_ext = {{(32 - `ASCM_OFS_W){instr[`ASCM_OFS_HI]}},
    instr[`ASCM_OFS_HI:`ASCM_OFS_LO]};
  assign eff_addr = base_value + ofs_ext; // RL2
  assign misaligned = eff_addr[1] | eff_addr[0]; // RL17
endmodule // ascm_decode

`default_nettype wire

// ===== logic/ascm_monitor.sv
/*
  Reservation monitor for load-linked / store-conditional word pairs.
  Holds the reservation, watches coherent and local traffic, decides the
  outcome of each conditional store, drives the memory write and the
  result written back to the data source register.
  The outcome is fixed in the issue cycle: a kill event in that cycle
  fails the store, one after it only meets the next link.
  Loads and prefetches are seen but never end the link, in either mode.
  Assumes the pipeline presents one instruction per valid strobe and that
  software keeps the pairing and memory-type rules below, and keeps
  conditional stores at least three cycles apart.
*/
// Contract
// RL1: Decode conditional store: opcode 011000, sub-function 1011, zero bits 11-9.
// RL2: Address is base plus sign-extended offset; success writes whole word.
// RL3: Success writes one into the data source register.
// RL4: Failure leaves memory alone and writes zero to the register.
// RL5: Other agents' coherent store into reserved block fails the store.
// RL6: Strict mode: own coherent store into block fails the store.
// RL7: Exception return fails; the keep-link variant leaves reservation.
// RL8: Store address differing from linked address fails the store.
// RL9: Strict mode: own load to block never fails; otherwise may.
// RL10: Own accesses elsewhere, prefetches, non-coherent stores may fail it.
// RL11: Instructions spanning over 2048 bytes may fail the store.
// RL12: Strict mode: local cache operations may fail; remote ones too.
// RL13: Strict mode: unpaired or mismatched store still gives definite result.
// RL14: Software pairs each store with a linked load at same address.
// RL15: One-processor atomicity needs consistent cached memory type.
// RL16: Multi-agent atomicity needs cached coherent type everywhere.
// RL17: Misaligned effective address raises address error, no store.
// RL18: Every conditional store clears the reservation flag; faulting stores here leave it set.
// RL19: Store may signal translation, address error and watch exceptions.
// RL20: Monitor holds flag and block address; linked load sets, reset clears.
// RL21: Write issued only if flag still set at commit.
`timescale 1ns/10ps
`default_nettype none
`include "ascm_params.svh"

module ascm_monitor #(
  parameter int BLOCK_LOG2 = `ASCM_BLOCK_LOG2,
  parameter int REGION_BYTES = `ASCM_REGION_BYTES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Configuration
  input wire logic strict_link_config,
  // Pipeline instruction issue
  input wire logic instr_valid,
  input wire logic [31:0] instr,
  input wire ascm_pkg::ascm_word_t base_value,
  input wire ascm_pkg::ascm_word_t dsr_value,
  input wire ascm_pkg::ascm_word_t pc,
  // Linked load from pipeline
  input wire logic load_linked_word,
  input wire ascm_pkg::ascm_word_t ll_addr,
  // Translation result for the store
  input wire ascm_pkg::ascm_word_t xlat_paddr,
  input wire logic xlat_refill,
  input wire logic xlat_invalid,
  input wire logic xlat_modified,
  input wire logic watch_hit,
  // Other pipeline events
  input wire logic exception_return,
  input wire logic exception_return_keep_link,
  input wire logic local_store,
  input wire logic local_store_coherent,
  input wire logic local_load,
  input wire logic local_prefetch,
  input wire logic local_cacheop,
  input wire ascm_pkg::ascm_word_t local_addr,
  // Coherent memory system snoops
  input wire logic snoop_store,
  input wire logic snoop_cacheop,
  input wire ascm_pkg::ascm_word_t snoop_addr,
  // Memory write
  output logic mem_wr,
  output ascm_pkg::ascm_word_t mem_addr,
  output ascm_pkg::ascm_word_t mem_data,
  // Register writeback
  output logic rf_wr,
  output ascm_pkg::ascm_reg_t rf_index,
  output ascm_pkg::ascm_word_t rf_data,
  // Exceptions
  output logic exc_valid,
  output logic [4:0] exc_code,
  // Monitor state
  output logic reservation_valid
);
  import ascm_pkg::*;

  ascm_word_t resv_addr;
  logic resv_flag;
  ascm_state_e state;
  logic is_scw;
  ascm_reg_t dsr_index;
  ascm_word_t eff_addr;
  logic misaligned;
  logic too_wide;
  logic scw_go;
  logic scw_take;
  logic store_fault;
  logic next_resv;
  logic snoop_kill;
  logic local_kill;
  logic lost;
  logic addr_match;
  logic xlat_fault;
  logic commit_ok;
  // Held from the issue cycle for the later write and writeback
  ascm_word_t hold_data;
  ascm_reg_t hold_index;
  ascm_word_t hold_paddr;
  logic hold_ok;

  function automatic logic same_block(input ascm_word_t a,
      input ascm_word_t b);
    same_block = (a >> BLOCK_LOG2) == (b >> BLOCK_LOG2);
  endfunction

  // A block spans one word at least and one small page at most
  if (BLOCK_LOG2 < 2 || BLOCK_LOG2 > 12) begin : g_bad_block
    $error("ascm_monitor: block must be a word up to a page");
  end
  // The span check needs room for one instruction word
  if (REGION_BYTES < 4) begin : g_bad_region
    $error("ascm_monitor: region too small");
  end

  ascm_decode ascm_decode_i (
    .instr(instr),
    .base_value(base_value),
    .is_scw(is_scw),
    .dsr_index(dsr_index),
    .eff_addr(eff_addr),
    .misaligned(misaligned)
  );

  ascm_region #(.REGION_BYTES(REGION_BYTES)) ascm_region_i (
    .mclk(mclk),
    .rstn(rstn),
    .start(load_linked_word),
    .pc_valid(instr_valid),
    .pc(pc),
    .too_wide(too_wide)
  );

  assign scw_go = instr_valid && is_scw && state == ascm_idle;
  // Faulting stores trap instead and leave the link alone
  assign store_fault = misaligned || xlat_fault;
  assign scw_take = scw_go && !store_fault;

  // Events that end the reservation
  assign snoop_kill = (snoop_store && same_block(snoop_addr, resv_addr)) // RL5
    || (snoop_cacheop && same_block(snoop_addr, resv_addr)); // RL12
  always_comb begin
    local_kill = 1'b0;
    if (exception_return && !exception_return_keep_link) begin
      local_kill = 1'b1; // RL7
    end
    if (local_store_coherent && same_block(local_addr, resv_addr)
        && strict_link_config) begin
      local_kill = 1'b1; // RL6
    end
    if (local_store && !local_store_coherent
        && same_block(local_addr, resv_addr)) begin
      local_kill = 1'b1; // RL10
    end
    if (local_cacheop && strict_link_config) begin
      local_kill = 1'b1; // RL12
    end
    // Loads, prefetches and out-of-block stores keep the link here RL9
    if (too_wide) begin
      local_kill = 1'b1; // RL11
    end
  end
  assign lost = snoop_kill || local_kill;

  assign addr_match = {eff_addr[31:2], 2'b00} == resv_addr; // RL8
  assign xlat_fault = xlat_refill || xlat_modified || xlat_invalid
    || watch_hit;
  // Later kills cannot reach a store already captured
  // Unpaired store sees a cleared flag: definite failure RL13
  assign commit_ok = resv_flag && !lost && addr_match; // RL21

  // One next value feeds both the flag and its port copy
  always_comb begin
    next_resv = resv_flag;
    if (load_linked_word) begin
      next_resv = 1'b1; // RL20
    end else if (scw_take || lost) begin
      next_resv = 1'b0; // RL18
    end
  end

  // Reservation flag and linked word address
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      resv_flag <= 1'b0; // RL20
      resv_addr <= 32'h00000000;
    end else begin
      resv_flag <= next_resv;
      if (load_linked_word) begin
        resv_addr <= {ll_addr[31:2], 2'b00};
      end
    end
  end

  // Store sequencing: capture, write memory, write register
  // Busy stores are dropped; the pipeline must space them
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= ascm_idle;
      hold_data <= 32'h00000000;
      hold_index <= 5'h00;
      hold_paddr <= 32'h00000000;
      hold_ok <= 1'b0;
    end else begin
      case (state)
        ascm_idle: begin
          if (scw_take) begin
            hold_data <= dsr_value;
            hold_index <= dsr_index;
            hold_paddr <= {xlat_paddr[31:2], 2'b00};
            hold_ok <= commit_ok;
            state <= ascm_store;
          end
        end
        ascm_store: begin
          state <= ascm_wrback;
        end
        ascm_wrback: begin
          state <= ascm_idle;
        end
        default: begin
          state <= ascm_idle;
        end
      endcase
    end
  end

  // Memory port
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mem_wr <= 1'b0;
      mem_addr <= 32'h00000000;
      mem_data <= 32'h00000000;
    end else begin
      mem_wr <= (state == ascm_store) && hold_ok; // RL21
      if (state == ascm_store && hold_ok) begin
        mem_addr <= hold_paddr; // RL2
        mem_data <= hold_data; // RL2
      end
    end
  end

  // Register writeback of the outcome
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rf_wr <= 1'b0;
      rf_index <= 5'h00;
      rf_data <= 32'h00000000;
    end else begin
      rf_wr <= state == ascm_wrback;
      if (state == ascm_wrback) begin
        rf_index <= hold_index;
        rf_data <= hold_ok ? `ASCM_RESULT_OK // RL3
          : `ASCM_RESULT_FAIL; // RL4
      end
    end
  end

  // Exceptions replace the store; codes are this core's own numbering
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      exc_valid <= 1'b0;
      exc_code <= 5'h00;
    end else begin
      exc_valid <= scw_go && store_fault; // RL19
      if (scw_go && misaligned) begin
        exc_code <= 5'h05; // RL17
      end else if (scw_go && xlat_refill) begin
        exc_code <= 5'h03; // RL19
      end else if (scw_go && xlat_invalid) begin
        exc_code <= 5'h03;
      end else if (scw_go && xlat_modified) begin
        exc_code <= 5'h01;
      end else if (scw_go && watch_hit) begin
        exc_code <= 5'h17;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reservation_valid <= 1'b0;
    end else begin
      reservation_valid <= next_resv; // RL20
    end
  end
endmodule // ascm_monitor

`default_nettype wire

// ===== logic/ascm_params.svh
/*
  Constants for the conditional-store reservation monitor: instruction
  encoding fields, block and region sizes, result codes.
  Assumes a 32-bit word machine with byte addresses.
*/
`ifndef ASCM_PARAMS_SVH
`define ASCM_PARAMS_SVH

`define ASCM_MAJOR_OPC 6'h18
`define ASCM_SUBFN_SCW 4'hB
`define ASCM_ZERO_FLD 3'h0
`define ASCM_MAJOR_HI 31
`define ASCM_MAJOR_LO 26
`define ASCM_DSR_HI 25
`define ASCM_DSR_LO 21
`define ASCM_BASE_HI 20
`define ASCM_BASE_LO 16
`define ASCM_SUBFN_HI 15
`define ASCM_SUBFN_LO 12
`define ASCM_ZERO_HI 11
`define ASCM_ZERO_LO 9
`define ASCM_OFS_HI 8
`define ASCM_OFS_LO 0
`define ASCM_OFS_W 9
`define ASCM_BLOCK_LOG2 4
`define ASCM_REGION_BYTES 2048
`define ASCM_RESULT_OK 32'h00000001
`define ASCM_RESULT_FAIL 32'h00000000
`define ASCM_STRICT_RESET 1'h0

`endif

// ===== logic/ascm_pkg.sv
/*
  Types shared by the reservation monitor modules.
  Assumes nothing beyond the constants header.
*/
package ascm_pkg;
  typedef logic [31:0] ascm_word_t;
  typedef logic [4:0] ascm_reg_t;
  typedef enum logic [1:0] {
    ascm_idle = 2'b00,
    ascm_store = 2'b01,
    ascm_wrback = 2'b10
  } ascm_state_e;
  typedef enum logic [1:0] {
    ascm_exc_none = 2'b00,
    ascm_exc_addr = 2'b01
  } ascm_exc_e;
endpackage

// ===== logic/ascm_region.sv
/*
  Tracks the span of instruction addresses fetched since the linked load
  and flags when it exceeds one contiguous region.
  Assumes pc_valid marks each retired instruction.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ascm_params.svh"

module ascm_region #(
  parameter int REGION_BYTES = `ASCM_REGION_BYTES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Instruction stream
  input wire logic start,
  input wire logic pc_valid,
  input wire ascm_pkg::ascm_word_t pc,
  // Result
  output logic too_wide
);
  import ascm_pkg::*;

  ascm_word_t lo_pc;
  ascm_word_t hi_pc;
  ascm_word_t next_lo;
  ascm_word_t next_hi;

  // A region narrower than one word can hold no instruction
  if (REGION_BYTES < 4) begin : g_bad_region
    $error("ascm_region: region too small");
  end

  always_comb begin
    next_lo = (pc < lo_pc) ? pc : lo_pc;
    next_hi = (pc > hi_pc) ? pc : hi_pc;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lo_pc <= 32'h00000000;
      hi_pc <= 32'h00000000;
    end else if (start) begin
      lo_pc <= pc;
      hi_pc <= pc;
    end else if (pc_valid) begin
      lo_pc <= next_lo;
      hi_pc <= next_hi;
    end
  end

  // Span measured inclusive of the last word
  assign too_wide = (hi_pc - lo_pc) > 32'(REGION_BYTES - 4); // RL11
endmodule // ascm_region

`default_nettype wire
